// ===== cpirq_pkg.sv
// Purpose: Constants and types for the clock and power interrupt enable block
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: Only the sources listed below are implemented; other bits read zero
package cpirq_pkg;

	// -------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_EN_CLR = 8'h00;
	localparam logic [7:0] OFF_EN_SET = 8'h04;
	localparam logic [7:0] OFF_FLAG = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_EVT = 8'h10;
	localparam logic [7:0] OFF_EVT_MASK = 8'h14;

	// -------------------------------------------------------------
	// Source bit positions
	// -------------------------------------------------------------
	localparam int BIT_PLL_LOCK_RISE = 15;
	localparam int BIT_BROWNOUT_SYNC_READY = 11;
	localparam int BIT_BROWNOUT_DETECT = 10;
	localparam int BIT_BROWNOUT_READY = 9;
	localparam int BIT_FLL_REF_CLOCK_STOPPED = 8;
	localparam int BIT_FLL_COARSE_LOCK = 7;
	localparam int BIT_FLL_FINE_LOCK = 6;
	localparam int BIT_FLL_OUT_OF_BOUNDS = 5;
	localparam int BIT_FLL_READY = 4;
	localparam int BIT_OSC_8MHZ_READY = 3;

	// Implemented sources, all others are reserved
	localparam logic [31:0] SRC_MASK = 32'h00008FF8;

	// -------------------------------------------------------------
	// Reset values and responses
	// -------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register state carried together
	typedef struct packed {
		logic [31:0] en;
		logic [31:0] flag;
		logic [31:0] evt;
		logic [31:0] mask;
	} cpirq_regs_t;

	localparam cpirq_regs_t RST_REGS = '{RST_WORD, RST_WORD, RST_WORD, RST_WORD};

endpackage

// ===== cpirq_top.sv
// Purpose: Interrupt enable set/clear, flags and event status behind AXI4-Lite
// Assumes: Status inputs synchronous to aclk; one write and one read at a time
// Notes: Request per source is flag and enable; irq is the masked sticky event
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module cpirq_top #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [31:0] clock_power_status,
	output logic [31:0] irq_req,
	output logic irq
);

	// -------------------------------------------------------------
	// Parameter check
	// -------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 32)
	begin : g_bad_addr
		$error("ADDR_W must be 5 to 32");
	end

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	cpirq_pkg::cpirq_regs_t regs_q;
	cpirq_pkg::cpirq_regs_t regs_d;
	logic [31:0] status_prev_q;
	logic [31:0] irq_req_q;
	logic [31:0] irq_req_d;
	logic irq_q;
	logic irq_d;
	logic aw_hold_q;
	logic aw_hold_d;
	logic w_hold_q;
	logic w_hold_d;
	logic [7:0] waddr_q;
	logic [7:0] waddr_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic [3:0] wstrb_q;
	logic [3:0] wstrb_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic arready_q;
	logic arready_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	logic awready_q;
	logic wready_q;

	// Decoded write and read terms
	logic [31:0] strb_mask;
	logic [31:0] ones;
	logic [31:0] set_ones;
	logic [31:0] clr_ones;
	logic [31:0] fclr_ones;
	logic [31:0] rise;
	logic [31:0] evt_rdclr;
	logic do_wr;
	logic do_set;
	logic do_clr;
	logic do_fclr;
	logic wr_ok;
	logic rd_fire;
	logic [7:0] raddr;
	logic [31:0] rd_word;
	logic rd_ok;

	// -------------------------------------------------------------
	// Byte lane expansion
	// -------------------------------------------------------------
	for (genvar i = 0; i < 4; i++)
	begin : g_strb
		assign strb_mask[8*i +: 8] = {8{wstrb_q[i]}};
	end

	// Write decode
	assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
	assign ones = wdata_q & strb_mask;
	assign do_set = do_wr && (waddr_q == cpirq_pkg::OFF_EN_SET);
	assign do_clr = do_wr && (waddr_q == cpirq_pkg::OFF_EN_CLR);
	assign do_fclr = do_wr && (waddr_q == cpirq_pkg::OFF_FLAG);
	assign clr_ones = do_clr ? (ones & cpirq_pkg::SRC_MASK) : 32'h00000000;
	assign fclr_ones = do_fclr ? (ones & cpirq_pkg::SRC_MASK) : 32'h00000000;

	// -------------------------------------------------------------
	// Per source set terms, zero bits and reserved bits do nothing
	// -------------------------------------------------------------
	always_comb
	begin
		set_ones = 32'h00000000;
		if (do_set)
		begin
			set_ones[cpirq_pkg::BIT_PLL_LOCK_RISE] = ones[cpirq_pkg::BIT_PLL_LOCK_RISE];
			set_ones[cpirq_pkg::BIT_BROWNOUT_SYNC_READY] =
				ones[cpirq_pkg::BIT_BROWNOUT_SYNC_READY];
			set_ones[cpirq_pkg::BIT_BROWNOUT_DETECT] = ones[cpirq_pkg::BIT_BROWNOUT_DETECT];
			set_ones[cpirq_pkg::BIT_BROWNOUT_READY] = ones[cpirq_pkg::BIT_BROWNOUT_READY];
			set_ones[cpirq_pkg::BIT_FLL_REF_CLOCK_STOPPED] =
				ones[cpirq_pkg::BIT_FLL_REF_CLOCK_STOPPED];
			set_ones[cpirq_pkg::BIT_FLL_COARSE_LOCK] = ones[cpirq_pkg::BIT_FLL_COARSE_LOCK];
			set_ones[cpirq_pkg::BIT_FLL_FINE_LOCK] = ones[cpirq_pkg::BIT_FLL_FINE_LOCK];
			set_ones[cpirq_pkg::BIT_FLL_OUT_OF_BOUNDS] = ones[cpirq_pkg::BIT_FLL_OUT_OF_BOUNDS];
			set_ones[cpirq_pkg::BIT_FLL_READY] = ones[cpirq_pkg::BIT_FLL_READY];
			set_ones[cpirq_pkg::BIT_OSC_8MHZ_READY] = ones[cpirq_pkg::BIT_OSC_8MHZ_READY];
		end
	end

	// -------------------------------------------------------------
	// Read decode
	// -------------------------------------------------------------
	assign rd_fire = arvalid && arready_q;
	assign raddr = {3'h0, araddr[4:2], 2'h0};

	// Unmapped until the word index decodes
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_ok = 1'b0;
		if ((araddr >> 5) == '0)
		begin
			rd_ok = 1'b1;
			case (raddr)
				cpirq_pkg::OFF_EN_CLR: rd_word = regs_q.en;
				cpirq_pkg::OFF_EN_SET: rd_word = regs_q.en;
				cpirq_pkg::OFF_FLAG: rd_word = regs_q.flag;
				cpirq_pkg::OFF_STATUS: rd_word = clock_power_status & cpirq_pkg::SRC_MASK;
				cpirq_pkg::OFF_EVT: rd_word = regs_q.evt;
				cpirq_pkg::OFF_EVT_MASK: rd_word = regs_q.mask;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// Read of the event register clears what it returned
	assign evt_rdclr = (rd_fire && rd_ok && raddr == cpirq_pkg::OFF_EVT) ? regs_q.evt :
		32'h00000000;

	// Write address check
	assign wr_ok = (waddr_q == cpirq_pkg::OFF_EN_CLR) || (waddr_q == cpirq_pkg::OFF_EN_SET) ||
		(waddr_q == cpirq_pkg::OFF_FLAG) || (waddr_q == cpirq_pkg::OFF_STATUS) ||
		(waddr_q == cpirq_pkg::OFF_EVT) || (waddr_q == cpirq_pkg::OFF_EVT_MASK);

	// -------------------------------------------------------------
	// Register file and interrupt next values
	// -------------------------------------------------------------
	always_comb
	begin
		regs_d = regs_q;
		rise = clock_power_status & ~status_prev_q & cpirq_pkg::SRC_MASK;
		regs_d.en = (regs_q.en | set_ones) & ~clr_ones;
		// write one clears, a new rise wins
		regs_d.flag = (regs_q.flag & ~fclr_ones) | rise;
		// Sticky event, set wins over read clear
		regs_d.evt = (regs_q.evt & ~evt_rdclr) | rise;
		if (do_wr && waddr_q == cpirq_pkg::OFF_EVT_MASK)
		begin
			regs_d.mask = (regs_q.mask & ~strb_mask) | (ones & cpirq_pkg::SRC_MASK);
		end
		irq_req_d = regs_d.flag & regs_d.en;
		irq_d = |(regs_d.evt & regs_d.mask);
	end

	// Register state update
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			regs_q <= cpirq_pkg::RST_REGS;
			status_prev_q <= cpirq_pkg::RST_WORD;
			irq_req_q <= cpirq_pkg::RST_WORD;
			irq_q <= 1'b0;
		end
		else
		begin
			regs_q <= regs_d;
			status_prev_q <= clock_power_status;
			irq_req_q <= irq_req_d;
			irq_q <= irq_d;
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite handshake next values
	// -------------------------------------------------------------
	always_comb
	begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		// Capture address and data in either order
		if (awvalid && !aw_hold_q)
		begin
			aw_hold_d = 1'b1;
			waddr_d = {{(8 - 5){1'b0}}, awaddr[4:2], 2'h0};
			if ((awaddr >> 5) != '0)
			begin
				waddr_d = 8'hFF;
			end
		end
		if (wvalid && !w_hold_q)
		begin
			w_hold_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		// Execute and answer
		if (do_wr)
		begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? cpirq_pkg::RESP_OKAY : cpirq_pkg::RESP_SLVERR;
		end
		else if (bvalid_q && bready)
		begin
			bvalid_d = 1'b0;
		end
		// Read path
		if (rd_fire)
		begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = rd_ok ? rd_word : 32'h00000000;
			rresp_d = rd_ok ? cpirq_pkg::RESP_OKAY : cpirq_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && rready)
		begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	// Bus state update
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			waddr_q <= 8'h00;
			wdata_q <= cpirq_pkg::RST_WORD;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= cpirq_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= cpirq_pkg::RST_WORD;
			rresp_q <= cpirq_pkg::RESP_OKAY;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= !aw_hold_d;
			wready_q <= !w_hold_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d | (!arready_q && !rvalid_q && !rvalid_d);
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Outputs straight from flops
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign irq_req = irq_req_q;
	assign irq = irq_q;

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_zero_keeps_en: assert property (
		((regs_q.en & ~$past(regs_q.en)) & ~$past(set_ones)) == 32'h00000000)
		else $error("enable rose without a one written");

	chk_set_takes_en: assert property (
		do_set |=> ((regs_q.en & $past(set_ones)) == $past(set_ones)))
		else $error("set write did not set enable");

	chk_fine_lock_set: assert property (
		(do_set && ones[cpirq_pkg::BIT_FLL_FINE_LOCK]) |=> regs_q.en[cpirq_pkg::BIT_FLL_FINE_LOCK])
		else $error("fine lock enable not set");

	chk_req_gated: assert property (
		irq_req == (regs_q.flag & regs_q.en))
		else $error("request not flag and enable");

	chk_clr_drops_en: assert property (
		do_clr |=> ((regs_q.en & $past(clr_ones)) == 32'h00000000))
		else $error("clear write left enable set");

	chk_flag_on_rise: assert property (
		(rise != 32'h00000000) |=> ((regs_q.flag & $past(rise)) == $past(rise)))
		else $error("flag not set on status rise");

	chk_flag_clears: assert property (
		(do_fclr && rise == 32'h00000000) |=> ((regs_q.flag & $past(fclr_ones)) == 32'h00000000))
		else $error("flag not cleared by write one");

	chk_rsv_reads_zero: assert property (
		(regs_q.en & ~cpirq_pkg::SRC_MASK) == 32'h00000000)
		else $error("reserved enable bit set");

	chk_reset_en_zero: assert property (disable iff (1'b0)
		!$past(aresetn) |-> (regs_q.en == 32'h00000000 && irq_req == 32'h00000000))
		else $error("enable not zero after reset");

	chk_irq_level: assert property (
		irq == |(regs_q.evt & regs_q.mask))
		else $error("irq does not follow masked events");

	chk_r_holds: assert property (
		(rvalid && !rready) |=> (rvalid && $stable(rdata)))
		else $error("read answer dropped early");

	chk_b_holds: assert property (
		(bvalid && !bready) |=> bvalid)
		else $error("write answer dropped early");

endmodule

// ===== tb_cpirq_top.sv
// Purpose: Self-checking bench for the clock and power interrupt enable block
// Assumes: One bus transfer of each kind at a time, replies in issue order
// Notes: Drivers queue expected bus results, a negedge monitor compares them
`timescale 1ns/1ps

module tb_cpirq_top;
	// ---------------------------------------------------------
	// Signals and reference state
	// ---------------------------------------------------------
	localparam logic [7:0] A_CLR = cpirq_pkg::OFF_EN_CLR;
	localparam logic [7:0] A_SET = cpirq_pkg::OFF_EN_SET;
	localparam logic [7:0] A_FLG = cpirq_pkg::OFF_FLAG;
	localparam logic [7:0] A_EVT = cpirq_pkg::OFF_EVT;
	localparam logic [7:0] A_MSK = cpirq_pkg::OFF_EVT_MASK;
	localparam logic [1:0] OK = cpirq_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = cpirq_pkg::RESP_SLVERR;
	localparam logic [31:0] SRC = cpirq_pkg::SRC_MASK;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic awready;
	logic wready;
	logic [3:0] strb_v = 4'hF;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [31:0] status = 32'h00000000;
	logic [31:0] irq_req;
	logic irq;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [31:0] en_m = 32'h00000000;
	logic [31:0] flag_m = 32'h00000000;
	logic [31:0] evt_m = 32'h00000000;
	logic [31:0] mask_m = 32'h00000000;
	logic [31:0] d;
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 86605;
	int bits[10] = '{15, 11, 10, 9, 8, 7, 6, 5, 4, 3};

	// Free running 10 MHz clock
	always #50 aclk = ~aclk;

	cpirq_top #(.ADDR_W(8)) u_dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.clock_power_status(status),
		.irq_req(irq_req),
		.irq(irq)
	);

	// ---------------------------------------------------------
	// Compare, bus tasks and monitor
	// ---------------------------------------------------------
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Write with address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ah;
		logic wh;
		logic bh;
		int n;
		@(posedge aclk);
		bq.push_back(er);
		awaddr <= a;
		wdata <= v;
		wstrb <= strb_v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		n = 0;
		while (bh !== 1'b1 && n < 50)
		begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			@(posedge aclk);
			if (ah === 1'b1)
				awvalid <= 1'b0;
			if (wh === 1'b1)
				wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		if (bh !== 1'b1)
			error_cnt++;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah;
		logic rh;
		int n;
		@(posedge aclk);
		rq.push_back({er, ed});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rh = 1'b0;
		n = 0;
		while (rh !== 1'b1 && n < 50)
		begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid;
			@(posedge aclk);
			if (ah === 1'b1)
				arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		if (rh !== 1'b1)
			error_cnt++;
	endtask

	// Status rise on the given bits, then back to idle
	task automatic pulse(input logic [31:0] s);
		@(posedge aclk);
		status <= s;
		flag_m = flag_m | (s & SRC);
		evt_m = evt_m | (s & SRC);
		rd(cpirq_pkg::OFF_STATUS, s & SRC, OK);
		status <= 32'h00000000;
		repeat (2) @(posedge aclk);
	endtask

	// Request lines against flag, enable, event and mask
	task automatic chk_irq();
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		cmp({2'b00, irq_req}, {2'b00, flag_m & en_m});
		cmp({33'h0, irq}, {33'h0, |(evt_m & mask_m)});
	endtask

	// Bus results taken off the queues in order
	always @(negedge aclk)
	begin
		if (aresetn && rvalid === 1'b1 && rready)
			cmp({rresp, rdata}, rq.pop_front());
		if (aresetn && bvalid === 1'b1 && bready)
			cmp({bresp, 32'h00000000}, {bq.pop_front(), 32'h00000000});
	end

	// Hang guard
	initial
	begin
		#1000000;
		error_cnt++;
		end_sim();
	end

	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(A_SET, 32'h00000000, OK);
		rd(A_CLR, 32'h00000000, OK);
		rd(A_FLG, 32'h00000000, OK);
		rd(A_MSK, 32'h00000000, OK);
		chk_irq();
		$display("test reset done");
		pulse(32'hFFFFFFFF);
		chk_irq();
		rd(A_FLG, flag_m, OK);
		$display("test flag rise done");
		foreach (bits[i])
		begin
			wr(A_SET, 32'h00000000, OK);
			rd(A_SET, en_m, OK);
			wr(A_SET, 32'h00000001 << bits[i], OK);
			en_m = en_m | (32'h00000001 << bits[i]);
			rd(A_SET, en_m, OK);
			chk_irq();
		end
		$display("test enable set done");
		repeat (8)
		begin
			d = $random(seed);
			wr(A_CLR, d, OK);
			en_m = en_m & ~d;
			rd(A_CLR, en_m, OK);
			chk_irq();
			d = $random(seed);
			wr(A_SET, d, OK);
			en_m = en_m | (d & SRC);
			rd(A_SET, en_m, OK);
			chk_irq();
		end
		// Byte strobes gate which ones land
		wr(A_CLR, 32'hFFFFFFFF, OK);
		en_m = 32'h00000000;
		strb_v = 4'h2;
		wr(A_SET, 32'hFFFFFFFF, OK);
		strb_v = 4'hF;
		en_m = SRC & 32'h0000FF00;
		rd(A_SET, en_m, OK);
		wr(A_SET, 32'hFFFFFFFF, OK);
		en_m = SRC;
		rd(A_SET, en_m, OK);
		$display("test random enables done");
		d = $random(seed);
		wr(A_FLG, d, OK);
		flag_m = flag_m & ~d;
		rd(A_FLG, flag_m, OK);
		chk_irq();
		wr(A_FLG, 32'hFFFFFFFF, OK);
		flag_m = 32'h00000000;
		chk_irq();
		$display("test flag clear done");
		wr(A_MSK, 32'h00000400, OK);
		mask_m = 32'h00000400;
		rd(A_MSK, mask_m, OK);
		chk_irq();
		rd(A_EVT, evt_m, OK);
		evt_m = 32'h00000000;
		chk_irq();
		wr(A_MSK, 32'h00000000, OK);
		mask_m = 32'h00000000;
		pulse(32'h00000400);
		chk_irq();
		wr(A_MSK, 32'h00000400, OK);
		mask_m = 32'h00000400;
		chk_irq();
		rd(A_EVT, evt_m, OK);
		evt_m = 32'h00000000;
		chk_irq();
		$display("test event irq done");
		wr(8'h20, 32'hFFFFFFFF, ERR);
		rd(8'h20, 32'h00000000, ERR);
		wr(cpirq_pkg::OFF_STATUS, 32'h00000000, OK);
		rd(A_SET, en_m, OK);
		chk_irq();
		$display("test refused access done");
		end_sim();
	end
endmodule
